//--- hw/bicwb_top.v
/*
 bicwb_top: idle state insertion between external bus cycles, idle pin
 states and the write data buffer, with an axi4-lite register slave.
 Assumes one clock, bus cycle requests held stable until taken, and
 external memory and i/o on the pins outside.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bicwb_map.vh"

module bicwb_top (
    input wire core_clk_in,
    input wire nrst_in,
    input wire [3:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    output wire [1:0] s_axi_bresp_out,
    output wire s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [3:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output wire [31:0] s_axi_rdata_out,
    output wire [1:0] s_axi_rresp_out,
    output wire s_axi_rvalid_out,
    input wire s_axi_rready_in,
    input wire req_valid_in,
    output wire req_ready_out,
    input wire req_internal_in,
    input wire req_write_in,
    input wire [1:0] req_area_in,
    input wire req_dram_in,
    input wire req_full_dram_in,
    input wire req_ras_down_in,
    input wire req_dma_sa_in,
    input wire [1:0] req_dack_ch_in,
    input wire [1:0] req_byte_en_in,
    input wire [19:0] req_addr_in,
    input wire [15:0] req_wdata_in,
    output wire int_go_out,
    output wire ext_done_out,
    output wire [19:0] addr_out,
    output wire [15:0] data_out,
    output wire data_oe_out,
    output wire [3:0] area_select_n_out,
    output wire read_strobe_n_out,
    output wire upper_write_strobe_n_out,
    output wire lower_write_strobe_n_out,
    output wire address_strobe_n_out,
    output wire upper_column_strobe_n_out,
    output wire lower_column_strobe_n_out,
    output wire row_strobe_n_out,
    output wire dram_write_n_out,
    output wire [3:0] dma_transfer_ack_n_out
);
    localparam ST_WAIT = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_EXT = 2'h2;

    reg [1:0] st_ff, nxt_st;
    reg [2:0] cnt_ff, nxt_cnt;
    reg [4:0] bus_control_ff;
    reg prev_valid_ff, prev_write_ff, prev_dma_ff;
    reg [1:0] prev_area_ff;
    reg cur_write_ff, cur_dram_ff, cur_full_ff, cur_ras_down_ff, cur_dma_ff;
    reg [1:0] cur_area_ff, cur_dack_ff, cur_be_ff;
    reg [19:0] cur_addr_ff;
    reg [15:0] cur_wdata_ff;
    reg aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
    reg [3:0] awaddr_ff;
    reg [31:0] wdata_ff, rdata_ff;
    reg [3:0] wstrb_ff;
    reg [1:0] bresp_ff, rresp_ff;
    wire [2:0] idle_count;
    wire wbuf_en, take, ext_take, in_idle, in_ext, last_ext, buf_ok;
    wire [2:0] ext_len;

    // decode of 2-bit selector into an active-low one-hot strobe group
    function [3:0] onehot_n;
        input [1:0] sel;
        input on;
        begin
            onehot_n = 4'hF;
            if (on)
                onehot_n[sel] = 1'b0;
        end
    endfunction

    assign wbuf_en = bus_control_ff[`BICWB_WBUF_EN_BIT];
    assign in_idle = (st_ff == ST_IDLE);
    assign in_ext = (st_ff == ST_EXT);
    assign ext_len = `BICWB_EXT_STATES + {2'h0, cur_full_ff};
    assign last_ext = in_ext && (cnt_ff == ext_len - 3'h1);
    // internal access overlaps only a buffered write or dma transfer, from its second state
    assign buf_ok = wbuf_en && in_ext && (cur_write_ff || cur_dma_ff)
        && cnt_ff != 3'h0;
    assign req_ready_out = (st_ff == ST_WAIT) || (req_internal_in && buf_ok);
    assign take = req_valid_in && req_ready_out;
    assign ext_take = take && !req_internal_in;
    assign int_go_out = take && req_internal_in;
    assign ext_done_out = last_ext;

    bicwb_idle_decide u_decide (
        .cond_in(bus_control_ff[`BICWB_IDLE_COND_HI:`BICWB_IDLE_COND_LO]),
        .len_in(bus_control_ff[`BICWB_IDLE_LEN_HI:`BICWB_IDLE_LEN_LO]),
        .prev_valid_in(prev_valid_ff),
        .prev_write_in(prev_write_ff),
        .prev_dma_in(prev_dma_ff),
        .prev_area_in(prev_area_ff),
        .cur_write_in(req_write_in),
        .cur_area_in(req_area_in),
        .cur_full_dram_in(req_full_dram_in),
        .idle_count_out(idle_count)
    );

    // bus cycle sequencer
    always @* begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            ST_WAIT: begin
                if (ext_take) begin
                    nxt_cnt = (idle_count != 3'h0) ? idle_count : 3'h0;
                    nxt_st = (idle_count != 3'h0) ? ST_IDLE : ST_EXT;
                end
            end
            ST_IDLE: begin
                if (cnt_ff == 3'h1) begin
                    nxt_st = ST_EXT;
                    nxt_cnt = 3'h0;
                end else begin
                    nxt_cnt = cnt_ff - 3'h1;
                end
            end
            ST_EXT: begin
                if (last_ext) begin
                    nxt_st = ST_WAIT;
                    nxt_cnt = 3'h0;
                end else begin
                    nxt_cnt = cnt_ff + 3'h1;
                end
            end
            default: begin
                nxt_st = ST_WAIT;
                nxt_cnt = 3'h0;
            end
        endcase
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff <= ST_WAIT;
            cnt_ff <= 3'h0;
            prev_valid_ff <= 1'b0;
            prev_write_ff <= 1'b0;
            prev_dma_ff <= 1'b0;
            prev_area_ff <= 2'h0;
            cur_write_ff <= 1'b0;
            cur_dram_ff <= 1'b0;
            cur_full_ff <= 1'b0;
            cur_ras_down_ff <= 1'b0;
            cur_dma_ff <= 1'b0;
            cur_area_ff <= 2'h0;
            cur_dack_ff <= 2'h0;
            cur_be_ff <= 2'h0;
            cur_addr_ff <= 20'h00000;
            cur_wdata_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            if (ext_take) begin
                cur_write_ff <= req_write_in;
                cur_dram_ff <= req_dram_in;
                cur_full_ff <= req_full_dram_in && req_dram_in;
                cur_ras_down_ff <= req_ras_down_in && req_dram_in;
                cur_dma_ff <= req_dma_sa_in;
                cur_area_ff <= req_area_in;
                cur_dack_ff <= req_dack_ch_in;
                cur_be_ff <= req_byte_en_in;
                cur_addr_ff <= req_addr_in;
                cur_wdata_ff <= req_wdata_in;
            end
            // record of the last external cycle only
            if (last_ext) begin
                prev_valid_ff <= 1'b1;
                prev_write_ff <= cur_write_ff;
                prev_dma_ff <= cur_dma_ff;
                prev_area_ff <= cur_area_ff;
            end
        end
    end

    // pins decoded from registered state
    wire strobe_ok, pre_state, col_state;
    assign strobe_ok = in_ext;
    assign pre_state = in_ext && cur_full_ff && cnt_ff == 3'h0;
    assign col_state = in_ext && cur_dram_ff && !pre_state;
    assign addr_out = cur_addr_ff;
    assign data_out = cur_wdata_ff;
    assign data_oe_out = strobe_ok && cur_write_ff;
    assign area_select_n_out = onehot_n(cur_area_ff,
        (strobe_ok && !pre_state) || (in_idle && cur_ras_down_ff));
    assign row_strobe_n_out = !((col_state) || (in_idle && cur_ras_down_ff));
    assign read_strobe_n_out = !(strobe_ok && !cur_write_ff && !cur_dram_ff);
    assign upper_write_strobe_n_out = !(strobe_ok && cur_write_ff && !cur_dram_ff
        && cur_be_ff[1]);
    assign lower_write_strobe_n_out = !(strobe_ok && cur_write_ff && !cur_dram_ff
        && cur_be_ff[0]);
    assign address_strobe_n_out = !(strobe_ok && !cur_dram_ff);
    assign upper_column_strobe_n_out = !(col_state && cur_be_ff[1]);
    assign lower_column_strobe_n_out = !(col_state && cur_be_ff[0]);
    assign dram_write_n_out = !(col_state && cur_write_ff);
    assign dma_transfer_ack_n_out = onehot_n(cur_dack_ff, strobe_ok && cur_dma_ff);

    // axi4-lite slave
    wire wr_fire, rd_fire, wr_hit, rd_bc, rd_st;
    assign s_axi_awready_out = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready_out = !w_have_ff && !bvalid_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = !rvalid_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
    assign wr_hit = awaddr_ff == `BICWB_BUS_CONTROL_OFFS;
    assign rd_fire = s_axi_arvalid_in && !rvalid_ff;
    assign rd_bc = s_axi_araddr_in == `BICWB_BUS_CONTROL_OFFS;
    assign rd_st = s_axi_araddr_in == `BICWB_STATUS_OFFS;

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bresp_ff <= `BICWB_RESP_OKAY;
            rresp_ff <= `BICWB_RESP_OKAY;
            rdata_ff <= 32'h00000000;
            bus_control_ff <= `BICWB_BUS_CONTROL_RST;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_hit || awaddr_ff == `BICWB_STATUS_OFFS) ?
                    `BICWB_RESP_OKAY : `BICWB_RESP_DECERR;
                if (wr_hit && wstrb_ff[0])
                    bus_control_ff <= wdata_ff[4:0];
            end else if (bvalid_ff && s_axi_bready_in) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rresp_ff <= (rd_bc || rd_st) ? `BICWB_RESP_OKAY : `BICWB_RESP_DECERR;
                if (rd_bc)
                    rdata_ff <= {27'h0000000, bus_control_ff};
                else if (rd_st)
                    rdata_ff <= {22'h000000, prev_area_ff, prev_dma_ff, prev_write_ff,
                        prev_valid_ff, cnt_ff, st_ff};
                else
                    rdata_ff <= 32'h00000000;
            end else if (rvalid_ff && s_axi_rready_in) begin
                rvalid_ff <= 1'b0;
            end
        end
    end
endmodule // bicwb_top

`default_nettype wire

//--- hw/bicwb_map.vh
/*
 bicwb_map.vh: register offsets, field positions, reset values and
 state counts for the bus idle cycle and write buffer block.
 Assumes it is included by bare name, in one compilation unit or several.
*/
`ifndef BICWB_MAP_VH
`define BICWB_MAP_VH

// register byte offsets
`define BICWB_BUS_CONTROL_OFFS 4'h0
`define BICWB_STATUS_OFFS 4'h4

// bus control register fields
`define BICWB_IDLE_LEN_LO 0
`define BICWB_IDLE_LEN_HI 1
`define BICWB_IDLE_COND_LO 2
`define BICWB_IDLE_COND_HI 3
`define BICWB_WBUF_EN_BIT 4
`define BICWB_BUS_CONTROL_RST 5'h0C

// axi response codes
`define BICWB_RESP_OKAY 2'h0
`define BICWB_RESP_DECERR 2'h3

// external cycle length in states, without precharge
`define BICWB_EXT_STATES 3'h2

`endif

//--- hw/bicwb_idle_decide.v
/*
 bicwb_idle_decide: works out how many idle states go in front of the
 next external cycle. Assumes the caller holds a record of the last
 external cycle and applies the result only to external cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module bicwb_idle_decide (
    input wire [1:0] cond_in,
    input wire [1:0] len_in,
    input wire prev_valid_in,
    input wire prev_write_in,
    input wire prev_dma_in,
    input wire [1:0] prev_area_in,
    input wire cur_write_in,
    input wire [1:0] cur_area_in,
    input wire cur_full_dram_in,
    output reg [2:0] idle_count_out
);
    reg hit;
    reg [2:0] total;

    always @* begin
        hit = 1'b0;
        total = {1'b0, len_in} + 3'h1;
        if (prev_valid_in && cond_in != 2'h0) begin
            if (prev_dma_in)
                hit = 1'b1;
            else if (!prev_write_in && !cur_write_in && prev_area_in != cur_area_in)
                hit = 1'b1;
            else if (!prev_write_in && cur_write_in && cond_in[1])
                hit = 1'b1;
            else if (prev_write_in && !cur_write_in && cond_in == 2'h3)
                hit = 1'b1;
        end
        if (!hit)
            idle_count_out = 3'h0;
        else if (cur_full_dram_in)
            idle_count_out = total - 3'h1;
        else
            idle_count_out = total;
    end
endmodule // bicwb_idle_decide

`default_nettype wire

//--- testbench/bicwb_ext_mem.sv
/*
 bicwb_ext_mem: external memory at the pins, keeps the last written halfword.
 Assumes the pin outputs of bicwb_top and the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module bicwb_ext_mem (
    input wire logic clk_in,
    input wire logic [3:0] area_sel_n_in,
    input wire logic upper_wr_n_in,
    input wire logic lower_wr_n_in,
    input wire logic data_oe_in,
    input wire logic [15:0] data_in,
    output logic [15:0] last_data_out
);
    // take data only while selected, strobed and driven
    always @(posedge clk_in) begin
        if (!(&area_sel_n_in) && !(upper_wr_n_in && lower_wr_n_in) && data_oe_in) begin
            last_data_out <= data_in;
        end
    end
endmodule // bicwb_ext_mem
`default_nettype wire

//--- testbench/bicwb_asserts.sv
/*
 bicwb_asserts: cycle timing and idle pin checks at the bicwb_top ports.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bicwb_asserts (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic req_valid_in,
    input wire logic req_internal_in,
    input wire logic req_ready_out,
    input wire logic int_go_out,
    input wire logic ext_done_out,
    input wire logic [19:0] addr_out,
    input wire logic data_oe_out,
    input wire logic read_strobe_n_out,
    input wire logic upper_write_strobe_n_out,
    input wire logic lower_write_strobe_n_out,
    input wire logic address_strobe_n_out,
    input wire logic [3:0] dma_transfer_ack_n_out
);
    logic take_ext;
    logic busy_ff;
    assign take_ext = req_valid_in && req_ready_out && !req_internal_in;
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) busy_ff <= 1'h0;
        else if (take_ext) busy_ff <= 1'h1;
        else if (ext_done_out) busy_ff <= 1'h0;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence ext_take; take_ext; endsequence
    sequence ext_end; ##[2:6] ext_done_out; endsequence
    sequence pins_quiet;
        read_strobe_n_out && upper_write_strobe_n_out && lower_write_strobe_n_out
            && address_strobe_n_out && dma_transfer_ack_n_out == 4'hF && !data_oe_out;
    endsequence
    busy_wait_a: assert property (ext_take |=> !req_ready_out)
        else $error("request accepted while a cycle runs");
    done_bound_a: assert property (ext_take |-> ext_end)
        else $error("external cycle length out of range");
    done_wait_a: assert property (ext_done_out |=> req_ready_out)
        else $error("not ready after cycle end");
    done_pins_a: assert property (ext_done_out |=> pins_quiet)
        else $error("strobes active after cycle end");
    strobe_data_a: assert property (!data_oe_out |-> upper_write_strobe_n_out
        && lower_write_strobe_n_out)
        else $error("write strobe with data floated");
    buf_write_a: assert property (int_go_out && busy_ff |->
        data_oe_out || dma_transfer_ack_n_out != 4'hF)
        else $error("internal access beside a non-write cycle");
    buf_first_a: assert property ($rose(data_oe_out) |-> !int_go_out)
        else $error("internal access in first write state");
    addr_hold_a: assert property (!take_ext |=> $stable(addr_out))
        else $error("address moved without a new cycle");
endmodule // bicwb_asserts
bind bicwb_top bicwb_asserts u_chk (.*);
`default_nettype wire

//--- testbench/bicwb_bench.sv
/*
 bicwb_bench: drives register and bus cycle ports, checks idle counts and pins.
 Assumes bicwb_top, bicwb_ext_mem and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module bicwb_bench;
    logic core_clk_in, nrst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic s_axi_arvalid_in, s_axi_rready_in, req_valid_in, req_internal_in, req_write_in;
    logic req_dram_in, req_full_dram_in, req_ras_down_in, req_dma_sa_in, pw, pd, hp;
    logic [3:0] s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
    logic [31:0] s_axi_wdata_in;
    logic [1:0] req_area_in, req_dack_ch_in, req_byte_en_in, pa;
    logic [19:0] req_addr_in;
    logic [15:0] req_wdata_in, last_wr;
    logic [4:0] cfg;
    wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    wire s_axi_rvalid_out, req_ready_out, int_go_out, ext_done_out, data_oe_out;
    wire read_strobe_n_out, upper_write_strobe_n_out, lower_write_strobe_n_out;
    wire address_strobe_n_out, upper_column_strobe_n_out, lower_column_strobe_n_out;
    wire row_strobe_n_out, dram_write_n_out;
    wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0] s_axi_rdata_out;
    wire [19:0] addr_out;
    wire [15:0] data_out;
    wire [3:0] area_select_n_out, dma_transfer_ack_n_out;
    integer failures, num_checks, c;
    bicwb_top DUT (.*);
    bicwb_ext_mem mem (.clk_in(core_clk_in), .area_sel_n_in(area_select_n_out),
        .upper_wr_n_in(upper_write_strobe_n_out), .lower_wr_n_in(lower_write_strobe_n_out),
        .data_oe_in(data_oe_out), .data_in(data_out), .last_data_out(last_wr));
    task report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task stuck;
        failures++;
        report_and_stop();
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [2:0] tk;
        @(posedge core_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        for (int t = 0; t < 40; t++) begin
            @(negedge core_clk_in);
            tk = {s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out};
            if (tk[0]) chk(s_axi_bresp_out, er);
            @(posedge core_clk_in);
            if (tk[2]) s_axi_awvalid_in <= 1'h0;
            if (tk[1]) s_axi_wvalid_in <= 1'h0;
            if (tk[0]) s_axi_bready_in <= 1'h0;
            if (tk[0]) return;
        end
        stuck();
    endtask
    task axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [1:0] tk;
        @(posedge core_clk_in);
        s_axi_araddr_in <= a;
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        for (int t = 0; t < 40; t++) begin
            @(negedge core_clk_in);
            tk = {s_axi_arready_out, s_axi_rvalid_out};
            if (tk[0]) chk(s_axi_rdata_out, ed);
            if (tk[0]) chk(s_axi_rresp_out, er);
            @(posedge core_clk_in);
            if (tk[1]) s_axi_arvalid_in <= 1'h0;
            if (tk[0]) s_axi_rready_in <= 1'h0;
            if (tk[0]) return;
        end
        stuck();
    endtask
    task req(input logic w, input logic [1:0] a, input logic [2:0] kd, input logic i,
        input logic b);
        integer k, j, g;
        logic dr;
        dr = |kd[1:0];
        g = (cfg[3:2] != 2'h0 && hp && (pd || (!pw && !w && pa != a) || (!pw && w && cfg[3])
            || (pw && !w && cfg[3:2] == 2'h3))) ? cfg[1:0] + 1 : kd[0];
        @(posedge core_clk_in);
        {req_valid_in, req_write_in, req_internal_in, req_area_in, req_dack_ch_in} <= {1'h1,
            w, i, a, a};
        {req_dma_sa_in, req_ras_down_in, req_full_dram_in, req_dram_in} <= {kd, |kd[1:0]};
        req_addr_in <= {a, 2'h2, num_checks[15:0]};
        req_wdata_in <= ~num_checks[15:0];
        req_byte_en_in <= {1'h1, a[0]};
        k = 0;
        j = 0;
        do begin
            @(negedge core_clk_in);
            k++;
        end while (!req_ready_out && k < 40);
        if (!req_ready_out) stuck();
        if (i) chk(int_go_out, 1);
        @(posedge core_clk_in);
        {req_valid_in, req_internal_in} <= {b, 1'h1};
        if (i) return;
        {pw, pa, pd, hp} = {w, a, kd[2], 1'h1};
        k = 0;
        do begin
            @(negedge core_clk_in);
            k++;
            if (k <= g) chk({dram_write_n_out, data_oe_out, read_strobe_n_out,
                upper_write_strobe_n_out,
                lower_write_strobe_n_out, address_strobe_n_out, upper_column_strobe_n_out,
                lower_column_strobe_n_out, dma_transfer_ack_n_out, addr_out},
                {12'hBFF, req_addr_in});
            if (k <= g) chk(kd[1] ? row_strobe_n_out : {row_strobe_n_out, area_select_n_out},
                kd[1] ? 32'h0 : 32'h1F);
            if (b && int_go_out && j == 0) j = k;
        end while (!ext_done_out && k < 40);
        if (!ext_done_out) stuck();
        chk({area_select_n_out, dma_transfer_ack_n_out, read_strobe_n_out,
            address_strobe_n_out, upper_write_strobe_n_out, lower_write_strobe_n_out,
            row_strobe_n_out, upper_column_strobe_n_out, lower_column_strobe_n_out,
            data_oe_out}, {~(4'h1 << a), kd[2] ? ~(4'h1 << a) : 4'hF, w || dr, dr,
            !w || dr, !w || dr || !a[0], !dr, !dr, !dr || !a[0], w});
        chk(k, g + 2);
        if (!b) return;
        chk(j, cfg[4] ? k : 0);
        if (!cfg[4]) @(negedge core_clk_in);
        chk(int_go_out, 1);
        chk(last_wr, req_wdata_in);
        @(posedge core_clk_in);
        req_valid_in <= 1'h0;
    endtask
    initial begin
        core_clk_in = 1'h0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    initial begin
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
        {s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 41'h0;
        {req_valid_in, req_internal_in, req_write_in, req_dram_in, req_full_dram_in} = 5'h0;
        {req_ras_down_in, req_dma_sa_in, req_area_in, req_dack_ch_in, req_addr_in} = 26'h0;
        {req_wdata_in, s_axi_wstrb_in, req_byte_en_in, hp, nrst_in} = 24'h3F8;
        {failures, num_checks} = 64'h0;
        repeat (4) @(posedge core_clk_in);
        nrst_in <= 1'h1;
        axi_rd(4'h0, 32'hC, 2'h0);
        axi_rd(4'h4, 32'h0, 2'h0);
        axi_wr(4'h4, 32'h1F, 2'h0);
        axi_rd(4'h0, 32'hC, 2'h0);
        axi_wr(4'h8, 32'h1F, 2'h3);
        axi_rd(4'h8, 32'h0, 2'h3);
        for (c = 0; c < 18; c++) begin
            cfg = (c < 16) ? c[4:0] : {c[0], 4'hC};
            axi_wr(4'h0, {27'h0, cfg}, 2'h0);
            axi_rd(4'h0, {27'h0, cfg}, 2'h0);
            req(1'h0, 2'h0, 3'h0, 1'h0, 1'h0);
            req(1'h0, 2'h0, 3'h0, 1'h1, 1'h0);
            req(1'h0, 2'h1, 3'h0, 1'h0, 1'h0);
            req(1'h1, 2'h1, 3'h0, 1'h0, 1'h0);
            req(1'h0, 2'h1, 3'h0, 1'h0, 1'h0);
            req(1'h1, 2'h1, 3'h4, 1'h0, 1'h0);
            req(1'h0, 2'h1, 3'h0, 1'h0, 1'h0);
            req(1'h0, 2'h2, 3'h1, 1'h0, 1'h0);
            req(1'h0, 2'h3, 3'h2, 1'h0, 1'h0);
            req(1'h1, 2'h3, 3'h0, 1'h0, 1'h0);
            req(1'h1, 2'h3, 3'h0, 1'h0, c > 15);
        end
        axi_rd(4'h4, 32'h360, 2'h0);
        report_and_stop();
    end
endmodule // bicwb_bench
`default_nettype wire
